// file: logic/ioa_cmd_core.sv
// Command frame interpreter: input read, calculate and compare
`timescale 1ns/1ps
`default_nettype none
module ioa_cmd_core (
    input  wire logic                core_clk_i,
    input  wire logic                srst_i,
    input  wire logic [4:0]          avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic [31:0]         avs_writedata_i,
    input  wire logic [3:0]          avs_byteenable_i,
    output logic [31:0]              avs_readdata_o,
    output logic                     avs_waitrequest_o,
    input  wire ioa_pkg::ioa_io_in_t io_i,
    output ioa_pkg::ioa_flags_t      cmp_flags_o
);
    import ioa_pkg::*;

    // ****************************************
    // State and frame decode
    // ****************************************
    ioa_state_t  st_q;
    ioa_state_t  st_d;
    logic        req;
    logic        rd_take;
    logic        wr_take;
    logic [31:0] be_mask;
    logic [31:0] rd_mux;
    logic [7:0]  ex_target;
    logic [7:0]  ex_instr;
    logic [7:0]  ex_type;
    logic [7:0]  ex_bank;
    logic [31:0] ex_value;
    logic        chk_ok;
    logic        exec_take;
    logic        exec_ok;
    logic        port_ok;
    logic [1:0]  port_ix;
    logic        din_sel;
    logic [15:0] adc_sel;
    logic        dout_sel;
    logic [31:0] gio_val;
    logic [7:0]  gio_stat;
    logic [31:0] alu_res;
    logic        alu_div0;
    ioa_flags_t  alu_flags;
    logic [31:0] tx_value;

    assign ex_target = st_q.rx[FB_TARGET];
    assign ex_instr  = st_q.rx[FB_INSTR];
    assign ex_type   = st_q.rx[FB_TYPE];
    assign ex_bank   = st_q.rx[FB_BANK];
    assign ex_value  = {st_q.rx[FB_VAL3], st_q.rx[FB_VAL2],
                        st_q.rx[FB_VAL1], st_q.rx[FB_VAL0]};
    assign chk_ok    = (ioa_chk_sum(st_q.rx) == st_q.rx[FB_CHK]);
    assign exec_take = (st_q.phase == PH_EXEC) && (ex_target == st_q.mod_addr);
    assign exec_ok   = exec_take && chk_ok;
    assign tx_value  = {st_q.tx[FB_VAL3], st_q.tx[FB_VAL2],
                        st_q.tx[FB_VAL1], st_q.tx[FB_VAL0]};

    // ****************************************
    // Input selection for get-input
    // ****************************************
    // Digital and analog views are both live, no mode to switch
    assign port_ok  = (ex_type < PORT_COUNT);
    assign port_ix  = ex_type[1:0];
    assign din_sel  = io_i.din[port_ix];
    assign adc_sel  = io_i.adc[port_ix];
    assign dout_sel = io_i.dout[port_ix];

    always_comb
    begin
        gio_val  = '0;
        gio_stat = ST_OK;
        if (ex_bank > BANK_DOUT)
        begin
            gio_stat = ST_BAD_VAL;
        end
        else if ((ex_bank == BANK_DIN) && (ex_type == PORT_ALL))
        begin
            gio_val = {28'h0000000, io_i.din};
        end
        else if ((ex_bank == BANK_DIN) && (ex_type == PORT_ENABLE))
        begin
            gio_val = {31'h00000000, ~io_i.drv_en};
        end
        else if (!port_ok)
        begin
            gio_stat = ST_BAD_TYPE;
        end
        else if (ex_bank == BANK_DIN)
        begin
            gio_val = {31'h00000000, din_sel};
        end
        else if (ex_bank == BANK_ADC)
        begin
            gio_val = {16'h0000, adc_sel};
        end
        else
        begin
            gio_val = {31'h00000000, dout_sel};
        end
    end

    ioa_calculate_cmd_alu u_alu (
        .op_i       (ioa_calculate_cmd_op_t'(ex_type[3:0])),
        .acc_i      (st_q.acc),
        .operand_i  (ex_value),
        .result_o   (alu_res),
        .div_zero_o (alu_div0),
        .flags_o    (alu_flags)
    );

    // ****************************************
    // Avalon-MM slave, one wait state
    // ****************************************
    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~st_q.ack;
    assign rd_take           = avs_read_i & st_q.ack;
    assign wr_take           = avs_write_i & st_q.ack;
    assign avs_readdata_o    = st_q.rdata;
    assign cmp_flags_o       = st_q.flags;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            be_mask[i*8 +: 8] = {8{avs_byteenable_i[i]}};
        end
    end

    // Unmapped and write-only offsets read as zero
    always_comb
    begin
        rd_mux = '0;
        if (avs_address_i == REG_CTRL)
        begin
            rd_mux[CTRL_ALONE]          = st_q.standalone;
            rd_mux[CTRL_MOD_LSB +: 8]   = st_q.mod_addr;
            rd_mux[CTRL_HOST_LSB +: 8]  = st_q.host_addr;
        end
        else if (avs_address_i == REG_STATUS)
        begin
            rd_mux = {19'h00000, st_q.flags.lt, st_q.flags.gt, st_q.flags.eq,
                      st_q.chk_err, st_q.tx_cnt, st_q.rx_cnt, st_q.phase == PH_TX};
        end
        else if ((avs_address_i == REG_TX) && (st_q.phase == PH_TX))
        begin
            rd_mux = {24'h000000, st_q.tx[st_q.tx_cnt]};
        end
        else if (avs_address_i == REG_ACCU)
        begin
            rd_mux = st_q.acc;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic [7:0]  r_stat;
        logic [31:0] r_val;
        r_stat = ST_OK;
        r_val  = ex_value;
        st_d     = st_q;
        st_d.ack = req & ~st_q.ack;
        if (avs_read_i && !st_q.ack)
        begin
            st_d.rdata = rd_mux;
        end
        if (wr_take && (avs_address_i == REG_CTRL))
        begin
            if (avs_byteenable_i[0])
            begin
                st_d.standalone = avs_writedata_i[CTRL_ALONE];
            end
            if (avs_byteenable_i[1])
            begin
                st_d.mod_addr = avs_writedata_i[CTRL_MOD_LSB +: 8];
            end
            if (avs_byteenable_i[2])
            begin
                st_d.host_addr = avs_writedata_i[CTRL_HOST_LSB +: 8];
            end
        end
        if (wr_take && (avs_address_i == REG_ACCU))
        begin
            st_d.acc = (st_q.acc & ~be_mask) | (avs_writedata_i & be_mask);
        end
        unique case (st_q.phase)
            PH_RX:
            begin
                // Bytes arrive in frame order, target address first
                if (wr_take && (avs_address_i == REG_RX) && avs_byteenable_i[0])
                begin
                    st_d.rx[st_q.rx_cnt] = avs_writedata_i[7:0];
                    st_d.rx_cnt          = st_q.rx_cnt + 4'h1;
                    if (st_q.rx_cnt == FRAME_LAST_IX)
                    begin
                        st_d.rx_cnt = '0;
                        st_d.phase  = PH_EXEC;
                    end
                end
            end
            PH_EXEC:
            begin
                // Frames for another address are dropped without reply
                st_d.phase = PH_RX;
                if (exec_take)
                begin
                    st_d.chk_err = !chk_ok;
                    if (!chk_ok)
                    begin
                        r_stat = ST_BAD_CHK;
                    end
                    else if (ex_instr == INSTR_GIO)
                    begin
                        r_val  = gio_val;
                        r_stat = gio_stat;
                        if (gio_stat == ST_OK)
                        begin
                            if (st_q.standalone || (ex_type == PORT_ALL))
                            begin
                                st_d.acc = gio_val;
                            end
                        end
                    end
                    else if (ex_instr == INSTR_CALCULATE_CMD)
                    begin
                        // Division by zero keeps the accumulator and reports it
                        if (ex_type > CALCULATE_CMD_OP_LAST)
                        begin
                            r_stat = ST_BAD_TYPE;
                        end
                        else if (alu_div0)
                        begin
                            r_stat = ST_BAD_VAL;
                        end
                        else
                        begin
                            st_d.acc = alu_res;
                        end
                    end
                    else if (ex_instr == INSTR_COMP)
                    begin
                        st_d.flags = alu_flags;
                    end
                    else
                    begin
                        r_stat = ST_BAD_CMD;
                    end
                    st_d.phase                                 = PH_TX;
                    st_d.tx_cnt                                = '0;
                    st_d.tx[RB_HOST]                           = st_q.host_addr;
                    st_d.tx[RB_TARGET]                         = st_q.mod_addr;
                    st_d.tx[RB_STATUS]                         = r_stat;
                    st_d.tx[RB_INSTR]                          = ex_instr;
                    {st_d.tx[FB_VAL3], st_d.tx[FB_VAL2],
                     st_d.tx[FB_VAL1], st_d.tx[FB_VAL0]}       = r_val;
                    st_d.tx[FB_CHK]                            = ioa_chk_sum(st_d.tx);
                end
            end
            PH_TX:
            begin
                // Frame bytes written before the whole reply is read are dropped
                if (rd_take && (avs_address_i == REG_TX))
                begin
                    st_d.tx_cnt = st_q.tx_cnt + 4'h1;
                    if (st_q.tx_cnt == FRAME_LAST_IX)
                    begin
                        st_d.tx_cnt = '0;
                        st_d.phase  = PH_RX;
                    end
                end
            end
        endcase
        if (wr_take && (avs_address_i == REG_CTRL) && avs_byteenable_i[3]
            && avs_writedata_i[CTRL_ABORT])
        begin
            st_d.phase  = PH_RX;
            st_d.rx_cnt = '0;
            st_d.tx_cnt = '0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            st_q <= IOA_ST_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_gio_din;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_ok && (ex_instr == INSTR_GIO) && (ex_bank == BANK_DIN) && port_ok
        |=> tx_value == {31'h00000000, $past(din_sel)};
    endproperty
    a_gio_din: assert property (p_gio_din) else $error("digital input value wrong");

    property p_gio_all;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_ok && (ex_instr == INSTR_GIO) && (ex_bank == BANK_DIN) && (ex_type == PORT_ALL)
        |=> st_q.acc == {28'h0000000, $past(io_i.din)};
    endproperty
    a_gio_all: assert property (p_gio_all) else $error("input vector not loaded");

    property p_gio_adc;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_ok && (ex_instr == INSTR_GIO) && (ex_bank == BANK_ADC) && port_ok
        |=> tx_value == {16'h0000, $past(adc_sel)};
    endproperty
    a_gio_adc: assert property (p_gio_adc) else $error("analog value wrong");

    property p_gio_dout;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_ok && (ex_instr == INSTR_GIO) && (ex_bank == BANK_DOUT) && port_ok
        |=> tx_value == {31'h00000000, $past(dout_sel)};
    endproperty
    a_gio_dout: assert property (p_gio_dout) else $error("output state wrong");

    property p_gio_en;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_ok && (ex_instr == INSTR_GIO) && (ex_bank == BANK_DIN) && (ex_type == PORT_ENABLE)
        |=> tx_value == {31'h00000000, !$past(io_i.drv_en)};
    endproperty
    a_gio_en: assert property (p_gio_en) else $error("enable state wrong");

    property p_calculate_cmd_sub;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_ok && (ex_instr == INSTR_CALCULATE_CMD) && (ex_type == 8'h01)
        |=> st_q.acc == $past(st_q.acc) - $past(ex_value);
    endproperty
    a_calculate_cmd_sub: assert property (p_calculate_cmd_sub) else $error("subtract wrong");

    property p_calculate_cmd_not;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_ok && (ex_instr == INSTR_CALCULATE_CMD) && (ex_type == 8'h08)
        |=> st_q.acc == ~$past(st_q.acc);
    endproperty
    a_calculate_cmd_not: assert property (p_calculate_cmd_not) else $error("invert wrong");

    property p_calculate_cmd_load;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_ok && (ex_instr == INSTR_CALCULATE_CMD) && (ex_type == CALCULATE_CMD_OP_LAST)
        |=> st_q.acc == $past(ex_value);
    endproperty
    a_calculate_cmd_load: assert property (p_calculate_cmd_load) else $error("load wrong");

    property p_calculate_cmd_ok;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_ok && (ex_instr == INSTR_CALCULATE_CMD) && (ex_type <= CALCULATE_CMD_OP_LAST) && !alu_div0
        |=> (st_q.tx[RB_STATUS] == ST_OK) && (tx_value == $past(ex_value));
    endproperty
    a_calculate_cmd_ok: assert property (p_calculate_cmd_ok) else $error("calculate reply wrong");

    property p_comp;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_ok && (ex_instr == INSTR_COMP)
        |=> $stable(st_q.acc) && (st_q.flags.eq == ($past(st_q.acc) == $past(ex_value)));
    endproperty
    a_comp: assert property (p_comp) else $error("compare result wrong");

    property p_direct;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_ok && (ex_instr == INSTR_GIO) && !st_q.standalone && (ex_type != PORT_ALL)
        |=> $stable(st_q.acc) && (st_q.phase == PH_TX);
    endproperty
    a_direct: assert property (p_direct) else $error("direct read touched accumulator");

    property p_reply;
        @(posedge core_clk_i) disable iff (srst_i)
        $rose(st_q.phase == PH_TX)
        |-> (st_q.tx[RB_HOST] == st_q.host_addr) && (st_q.tx[RB_TARGET] == st_q.mod_addr)
            && (st_q.tx[FB_CHK] == ioa_chk_sum(st_q.tx));
    endproperty
    a_reply: assert property (p_reply) else $error("reply frame malformed");

    property p_bad_chk;
        @(posedge core_clk_i) disable iff (srst_i)
        exec_take && !chk_ok
        |=> (st_q.tx[RB_STATUS] == ST_BAD_CHK) && $stable(st_q.acc) && st_q.chk_err;
    endproperty
    a_bad_chk: assert property (p_bad_chk) else $error("bad checksum not refused");

endmodule : ioa_cmd_core
`default_nettype wire

// file: logic/ioa_pkg.sv
// Constants, types and helpers shared by the command-execution block
`default_nettype none
package ioa_pkg;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam int         FRAME_LAST    = 8;
    localparam logic [3:0] FRAME_LAST_IX = 4'h8;
    localparam int         FB_TARGET     = 0;
    localparam int         FB_INSTR      = 1;
    localparam int         FB_TYPE       = 2;
    localparam int         FB_BANK       = 3;
    localparam int         FB_VAL3       = 4;
    localparam int         FB_VAL2       = 5;
    localparam int         FB_VAL1       = 6;
    localparam int         FB_VAL0       = 7;
    localparam int         FB_CHK        = 8;
    localparam int         RB_HOST       = 0;
    localparam int         RB_TARGET     = 1;
    localparam int         RB_STATUS     = 2;
    localparam int         RB_INSTR      = 3;

    // ****************************************
    // Instructions, banks, ports, status codes
    // ****************************************
    localparam logic [7:0] INSTR_GIO     = 8'h0F;
    localparam logic [7:0] INSTR_CALCULATE_CMD    = 8'h13;
    localparam logic [7:0] INSTR_COMP    = 8'h14;
    localparam logic [7:0] BANK_DIN      = 8'h00;
    localparam logic [7:0] BANK_ADC      = 8'h01;
    localparam logic [7:0] BANK_DOUT     = 8'h02;
    localparam logic [7:0] PORT_COUNT    = 8'h04;
    localparam logic [7:0] PORT_ENABLE   = 8'h0A;
    localparam logic [7:0] PORT_ALL      = 8'hFF;
    localparam logic [7:0] CALCULATE_CMD_OP_LAST  = 8'h09;
    localparam logic [7:0] ST_OK         = 8'h64;
    localparam logic [7:0] ST_BAD_CHK    = 8'h01;
    localparam logic [7:0] ST_BAD_CMD    = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE   = 8'h03;
    localparam logic [7:0] ST_BAD_VAL    = 8'h04;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [4:0] REG_CTRL      = 5'h00;
    localparam logic [4:0] REG_STATUS    = 5'h04;
    localparam logic [4:0] REG_RX        = 5'h08;
    localparam logic [4:0] REG_TX        = 5'h0C;
    localparam logic [4:0] REG_ACCU      = 5'h10;
    localparam int         CTRL_ALONE    = 0;
    localparam int         CTRL_MOD_LSB  = 8;
    localparam int         CTRL_HOST_LSB = 16;
    localparam int         CTRL_ABORT    = 31;
    localparam logic [7:0] MOD_ADDR_RST  = 8'h01;
    localparam logic [7:0] HOST_ADDR_RST = 8'h02;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        CALCULATE_CMD_ADD, CALCULATE_CMD_SUB, CALCULATE_CMD_MUL, CALCULATE_CMD_DIV, CALCULATE_CMD_MOD,
        CALCULATE_CMD_AND, CALCULATE_CMD_OR, CALCULATE_CMD_XOR, CALCULATE_CMD_NOT, CALCULATE_CMD_LOAD
    } ioa_calculate_cmd_op_t;

    typedef enum logic [1:0] {PH_RX, PH_EXEC, PH_TX} ioa_phase_t;

    typedef logic [8:0][7:0] ioa_frame_t;

    typedef struct packed {
        logic eq;
        logic gt;
        logic lt;
    } ioa_flags_t;

    typedef struct packed {
        logic [3:0][15:0] adc;
        logic [3:0]       din;
        logic [3:0]       dout;
        logic             drv_en;
    } ioa_io_in_t;

    typedef struct packed {
        ioa_phase_t  phase;
        logic        ack;
        logic [31:0] rdata;
        logic        standalone;
        logic [7:0]  mod_addr;
        logic [7:0]  host_addr;
        logic [3:0]  rx_cnt;
        logic [3:0]  tx_cnt;
        ioa_frame_t  rx;
        ioa_frame_t  tx;
        logic [31:0] acc;
        ioa_flags_t  flags;
        logic        chk_err;
    } ioa_state_t;

    localparam ioa_state_t IOA_ST_RST = '{
        phase:     PH_RX,
        mod_addr:  MOD_ADDR_RST,
        host_addr: HOST_ADDR_RST,
        default:   '0
    };

    function automatic logic [7:0] ioa_chk_sum(input ioa_frame_t f);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < FRAME_LAST; i++)
        begin
            s = s + f[i];
        end
        return s;
    endfunction : ioa_chk_sum

endpackage : ioa_pkg
`default_nettype wire

// file: logic/ioa_calculate_cmd_alu.sv
// Accumulator arithmetic, logic and compare unit
`timescale 1ns/1ps
`default_nettype none
module ioa_calculate_cmd_alu (
    input  wire ioa_pkg::ioa_calculate_cmd_op_t op_i,
    input  wire logic [31:0]           acc_i,
    input  wire logic [31:0]           operand_i,
    output logic [31:0]                result_o,
    output logic                       div_zero_o,
    output ioa_pkg::ioa_flags_t        flags_o
);
    import ioa_pkg::*;

    logic [31:0] divisor;

    // Signed view: operands may be negative
    always_comb
    begin
        div_zero_o = (operand_i == '0) && ((op_i == CALCULATE_CMD_DIV) || (op_i == CALCULATE_CMD_MOD));
        // Safe divisor replaces a zero operand with 1 so the divide never sees zero
        divisor    = div_zero_o ? 32'h00000001 : operand_i;
        flags_o.eq = (acc_i == operand_i);
        flags_o.gt = ($signed(acc_i) > $signed(operand_i));
        flags_o.lt = ($signed(acc_i) < $signed(operand_i));
        unique case (op_i)
            CALCULATE_CMD_ADD:  result_o = acc_i + operand_i;
            CALCULATE_CMD_SUB:  result_o = acc_i - operand_i;
            CALCULATE_CMD_MUL:  result_o = acc_i * operand_i;
            CALCULATE_CMD_DIV:  result_o = $signed(acc_i) / $signed(divisor);
            CALCULATE_CMD_MOD:  result_o = $signed(acc_i) % $signed(divisor);
            CALCULATE_CMD_AND:  result_o = acc_i & operand_i;
            CALCULATE_CMD_OR:   result_o = acc_i | operand_i;
            CALCULATE_CMD_XOR:  result_o = acc_i ^ operand_i;
            CALCULATE_CMD_NOT:  result_o = ~acc_i;
            CALCULATE_CMD_LOAD: result_o = operand_i;
            default:   result_o = acc_i;
        endcase
    end

endmodule : ioa_calculate_cmd_alu
`default_nettype wire

// file: testbench/ioa_host_model.sv
// Host model: bus master carrying frame bytes
`timescale 1ns/1ps
`default_nettype none
module ioa_host_model (
    input  wire logic        core_clk_i,
    input  wire logic        wait_i,
    input  wire logic [31:0] rdata_i,
    output logic [4:0]       adr_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic [31:0]      wd_o
);
    initial
    begin
        {adr_o, rd_o, wr_o, wd_o} = '0;
    end
    // Strobe kept up between calls, never set twice in one step
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        {adr_o, wd_o, wr_o, rd_o} <= {a, d, w, ~w};
        repeat (20)
        begin
            @(posedge core_clk_i);
            if (wait_i === 1'b0)
            begin
                q = rdata_i;
                return;
            end
        end
        io_read_and_accumulator_ops_test.hang();
    endtask : xfer
    task automatic idle();
        {rd_o, wr_o} <= 2'b00;
    endtask : idle
endmodule : ioa_host_model
`default_nettype wire

// file: testbench/io_read_and_accumulator_ops_test.sv
// Self-checking bench of the command block
`timescale 1ns/1ps
`default_nettype none
module io_read_and_accumulator_ops_test;
    import ioa_pkg::*;
    logic        core_clk_i, srst_i, rd, wr, wt;
    logic [4:0]  adr;
    logic [31:0] wd, rdat, acc, v, o, e, seed;
    logic [95:0] r;
    ioa_io_in_t  io;
    ioa_flags_t  flg;
    int          bad_count, n_checks, k, i;
    logic [7:0]  pt[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0A, 8'hFF};
    ioa_cmd_core dut_u (.core_clk_i, .srst_i, .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .io_i(io), .cmp_flags_o(flg));
    ioa_host_model host_u (.core_clk_i, .wait_i(wt), .rdata_i(rdat), .adr_o(adr),
        .rd_o(rd), .wr_o(wr), .wd_o(wd));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] calculate_cmd(input logic [3:0] t, input logic [31:0] a, b);
        case (t)
            0: return a + b;
            1: return a - b;
            2: return $signed(a) * $signed(b);
            3: return $signed(a) / $signed(b);
            4: return $signed(a) % $signed(b);
            5: return a & b;
            6: return a | b;
            7: return a ^ b;
            8: return ~a;
            default: return b;
        endcase
    endfunction : calculate_cmd
    function automatic logic [31:0] gexp(input logic [7:0] p, b);
        if (b == BANK_ADC) return {16'h0, io.adc[p[1:0]]};
        if (b == BANK_DOUT) return {31'h0, io.dout[p[1:0]]};
        if (p == PORT_ENABLE) return {31'h0, ~io.drv_en};
        if (p == PORT_ALL) return {28'h0, io.din};
        return {31'h0, io.din[p[1:0]]};
    endfunction : gexp
    task automatic chk(input string nm, input logic [31:0] x, s);
        n_checks++;
        if (s !== x)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic hang();
        bad_count++;
        wrap_up();
    endtask : hang
    task automatic acc_chk();
        host_u.xfer(1'b0, REG_ACCU, 32'h0, v);
        chk("accu", acc, v);
    endtask : acc_chk
    task automatic cmd(input logic [7:0] ins, t, b, input logic [31:0] val,
                       input logic [7:0] st, input logic bad);
        logic [7:0] f[9];
        logic [7:0] s;
        f = '{8'h01, ins, t, b, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        s = '0;
        for (int j = 0; j < 8; j++) s += f[j];
        f[8] = s + {7'h0, bad};
        for (int j = 0; j < 9; j++) host_u.xfer(1'b1, REG_RX, {24'h0, f[j]}, v);
        v = '0;
        for (int j = 0; j < 8 && v[0] !== 1'b1; j++) host_u.xfer(1'b0, REG_STATUS, 32'h0, v);
        if (v[0] !== 1'b1) hang();
        for (int j = 0; j < 9; j++)
        begin
            host_u.xfer(1'b0, REG_TX, 32'h0, v);
            f[j] = v[7:0];
        end
        s = '0;
        for (int j = 0; j < 8; j++) s += f[j];
        chk("head", {8'h02, 8'h01, st, ins}, {f[0], f[1], f[2], f[3]});
        chk("sum", {24'h0, s}, {24'h0, f[8]});
        if (st == ST_OK) chk("value", e, {f[4], f[5], f[6], f[7]});
    endtask : cmd
    initial
    begin
        core_clk_i = 0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    initial
    begin
        bad_count = 0;
        n_checks = 0;
        seed = 32'h10;
        acc = '0;
        srst_i = 1;
        io = '0;
        repeat (12) @(posedge core_clk_i);
        srst_i <= 0;
        @(posedge core_clk_i);
        for (k = 0; k < 3; k++)
            for (i = 0; i < 6; i++)
                if (k == 0 || i < 4)
                begin
                    r = {rnd(), rnd(), rnd()};
                    io <= r[72:0];
                    @(posedge core_clk_i);
                    e = gexp(pt[i], k[7:0]);
                    if (pt[i] == PORT_ALL) acc = e;
                    cmd(INSTR_GIO, pt[i], k[7:0], rnd(), ST_OK, 0);
                    acc_chk();
                end
        for (i = 0; i < 10; i++)
        begin
            o = (i == 3 || i == 4) ? (rnd() | 32'h1) : rnd();
            e = o;
            cmd(INSTR_CALCULATE_CMD, i[7:0], 8'h00, o, ST_OK, 0);
            acc = calculate_cmd(i[3:0], acc, o);
            acc_chk();
        end
        host_u.xfer(1'b1, REG_CTRL, 32'h0002_0101, v);
        for (i = 0; i < 3; i++)
        begin
            o = (i == 0) ? acc : (i == 1) ? acc + 1 : acc - 1;
            e = o;
            cmd(INSTR_COMP, 8'h00, 8'h00, o, ST_OK, 0);
            chk("flags", {29'h0, acc == o, $signed(acc) > $signed(o),
                $signed(acc) < $signed(o)}, {29'h0, flg});
            acc_chk();
        end
        cmd(INSTR_GIO, 8'h00, 8'h00, 32'h0, ST_BAD_CHK, 1);
        acc_chk();
        cmd(8'h0E, 8'h00, BANK_DOUT, 32'h1, ST_BAD_CMD, 0);
        cmd(INSTR_GIO, 8'h00, 8'h03, 32'h0, ST_BAD_VAL, 0);
        cmd(INSTR_CALCULATE_CMD, 8'h03, 8'h00, 32'h0, ST_BAD_VAL, 0);
        acc_chk();
        e = gexp(8'h02, BANK_ADC);
        acc = e;
        cmd(INSTR_GIO, 8'h02, BANK_ADC, 32'h0, ST_OK, 0);
        acc_chk();
        host_u.idle();
        wrap_up();
    end
endmodule : io_read_and_accumulator_ops_test
`default_nettype wire
